// File: core/smcp_spi_front.v
// serial command front end with status register and write protection
`timescale 1ns/1ps
// Functional notes
// - write latch clear: no memory or status write takes effect
// - write latch set: memory writes only to blocks left unprotected
// - lock clear and latch set: block-protect bits may change
// - lock set: lock and protect bits change only with wp pin high
// - wp low with lock set freezes protect bits until wp high
// - wp high: protection from protect bits alone, status write allowed
// - protect 00 none, 01 upper quarter, 10 upper half, 11 all
// - clock level at select fall picks mode 0 (low) or 3 (high)
// - input sampled on rising clock, output changed on falling clock
// - one command per select-low period; host must raise select between
// - command byte first unless xip held, then 24-bit address, then data there
// - fast read takes mode byte after address setting or clearing xip
// - starts in single-line mode, quad mode flag reads zero
// - status read 05h shifts status after command, any time while awake and xip clear
// - 06h sets write latch, bit 1, needed before writes
// - 04h clears write latch
// - 01h writes status from following byte when protection allows
// - 03h streams read bytes from address while select low
// - 02h stores bytes from address while select low
// - 17h returns four tamper bytes
// - 4Bh returns the identification code
// - status layout: lock 7, quad 6, protect 3:2, latch 1
// - write latch zero after reset and after 04h
// - status write leaves quad flag and write latch untouched
// - asleep, only wake command is obeyed
`include "smcp_map.vh"
module smcp_spi_front #(
    parameter [31:0] DEVICE_ID = 32'h5A5A0001  // arbitrary value
)(
    input wire i_clk_sys,
    input wire i_rst,
    input wire i_sck,
    input wire i_cs_n,
    input wire i_si,
    input wire i_wp_n,
    input wire i_tamper_flag,
    input wire i_wr_ready,
    input wire i_rd_valid,
    input wire [7:0] i_rd_data,
    output reg o_so,
    output reg o_so_oe,
    output reg [7:0] o_status,
    output reg o_hw_protect,
    output reg o_sleep,
    output reg o_xip,
    output reg o_mode3,
    output reg o_wr_valid,
    output reg [16:0] o_wr_addr,
    output reg [7:0] o_wr_data,
    output reg o_wr_buf_ready,
    output reg o_rd_req,
    output reg [16:0] o_rd_addr
);
    // two-flop synchronisers; only stage two is read
    reg [3:0] sync1_r, sync2_r;
    reg sck_prev_r, cs_prev_r;
    wire sck_s = sync2_r[0];
    wire cs_n_s = sync2_r[1];
    wire si_s = sync2_r[2];
    wire wp_n_s = sync2_r[3];
    wire sck_rise = ~cs_n_s & sck_s & ~sck_prev_r;
    wire sck_fall = ~cs_n_s & ~sck_s & sck_prev_r;
    wire cs_fall = cs_prev_r & ~cs_n_s;
    reg [2:0] bit_cnt_r, idx_r, rsv_r;
    reg [6:0] rx_r;
    reg [7:0] cmd_r, tx_r, rd_byte_r;
    reg [`SMCP_ADDR_W-1:0] addr_r;
    reg lock_r, bp_hi_r, bp_lo_r, wel_r, sleep_r, xip_r;
    // write buffer, slot 0 is the head
    reg v0_r, v1_r;
    reg [24:0] d0_r, d1_r;
    wire [7:0] rx_byte = {rx_r, si_s};
    wire byte_done = sck_rise & (bit_cnt_r == 3'h7);
    wire [7:0] status_now = {lock_r, 1'b0, rsv_r[2:1], bp_hi_r, bp_lo_r,
                             wel_r, rsv_r[0]};
    wire [`SMCP_ADDR_W-1:0] addr_inc = addr_r + 1'b1;
    wire hw_prot = lock_r & ~wp_n_s;
    // status writable only with latch set and either lock clear or wp high
    wire sr_ok = wel_r & (~lock_r | wp_n_s);
    wire [1:0] top2 = addr_r[`SMCP_ADDR_W-1:`SMCP_ADDR_W-2];
    reg blk_prot;
    always @*
    begin
        case ({bp_hi_r, bp_lo_r})
            2'b00: blk_prot = 1'b0;
            2'b01: blk_prot = (top2 == 2'b11);
            2'b10: blk_prot = top2[1];
            default: blk_prot = 1'b1;
        endcase
    end
    wire mem_ok = wel_r & ~blk_prot;
    wire is_read = (cmd_r == `SMCP_CMD_READ) |
                   (cmd_r == `SMCP_CMD_FAST_READ);
    // index of the first data byte for this command
    wire [2:0] data_idx = (cmd_r == `SMCP_CMD_FAST_READ) ?
                          3'h5 : 3'h4;
    // push into the buffer; a word offered while full is lost
    wire push = byte_done & ~sleep_r & (cmd_r == `SMCP_CMD_WRITE) &
                (idx_r >= 3'h4) & mem_ok & o_wr_buf_ready;
    wire read_next = byte_done & ~sleep_r & is_read &
                     (idx_r >= data_idx - 3'h1);
    wire [`SMCP_ADDR_W-1:0] rd_base = (idx_r == `SMCP_IDX_ADDR_END) ?
        {addr_r[`SMCP_ADDR_W-9:0], rx_byte} : addr_r;
    always @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            sync1_r <= 4'hB;
            sync2_r <= 4'hB;
            sck_prev_r <= 1'b0;
            cs_prev_r <= 1'b1;
        end
        else
        begin
            sync1_r <= {i_wp_n, i_si, i_cs_n, i_sck};
            sync2_r <= sync1_r;
            sck_prev_r <= sck_s;
            cs_prev_r <= cs_n_s;
        end
    end
    // framing, command decode and status register
    always @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            bit_cnt_r <= 3'h0;
            idx_r <= 3'h0;
            rx_r <= 7'h00;
            cmd_r <= 8'h00;
            addr_r <= {`SMCP_ADDR_W{1'b0}};
            {lock_r, bp_hi_r, bp_lo_r} <= 3'h0;
            wel_r <= 1'b0;
            rsv_r <= 3'h0;
            sleep_r <= 1'b0;
            xip_r <= 1'b0;
            o_mode3 <= 1'b0;
            o_rd_req <= 1'b0;
            o_rd_addr <= {`SMCP_ADDR_W{1'b0}};
        end
        else
        begin
            o_rd_req <= 1'b0;
            if (cs_fall)
            begin
                // each select-low period starts a fresh command
                bit_cnt_r <= 3'h0;
                o_mode3 <= sck_s;
                // with xip held, the frame opens straight at the address
                idx_r <= xip_r ? 3'h1 : 3'h0;
                cmd_r <= xip_r ? `SMCP_CMD_FAST_READ : 8'h00;
            end
            else if (sck_rise)
            begin
                bit_cnt_r <= bit_cnt_r + 3'h1;
                rx_r <= rx_byte[6:0];
            end
            if (byte_done)
            begin
                if (idx_r != `SMCP_IDX_MAX)
                    idx_r <= idx_r + 3'h1;
                if (idx_r == 3'h0)
                begin
                    cmd_r <= rx_byte;
                    if (sleep_r)
                    begin
                        if (rx_byte == `SMCP_CMD_WAKE)
                            sleep_r <= 1'b0;
                    end
                    else if (rx_byte == `SMCP_CMD_LATCH_SET)
                        wel_r <= 1'b1;
                    else if (rx_byte == `SMCP_CMD_LATCH_CLEAR)
                        wel_r <= 1'b0;
                    else if (rx_byte == `SMCP_CMD_SLEEP)
                        sleep_r <= 1'b1;
                end
                else if (!sleep_r)
                begin
                    if (idx_r <= `SMCP_IDX_ADDR_END)
                        addr_r <= {addr_r[`SMCP_ADDR_W-9:0], rx_byte};
                    else if (cmd_r == `SMCP_CMD_WRITE)
                        addr_r <= addr_inc;
                    if (cmd_r == `SMCP_CMD_STATUS_WRITE && idx_r == 3'h1 &&
                        sr_ok)
                    begin
                        // quad flag and write latch are left alone
                        lock_r <= rx_byte[`SMCP_SR_LOCK];
                        bp_hi_r <= rx_byte[`SMCP_SR_BP_HI];
                        bp_lo_r <= rx_byte[`SMCP_SR_BP_LO];
                        rsv_r <= {rx_byte[`SMCP_SR_RSV2],
                                  rx_byte[`SMCP_SR_RSV1],
                                  rx_byte[`SMCP_SR_RSV0]};
                    end
                    if (cmd_r == `SMCP_CMD_FAST_READ &&
                        idx_r == `SMCP_IDX_MODE)
                    begin
                        if (rx_byte == `SMCP_XIP_SET)
                            xip_r <= 1'b1;
                        else if (rx_byte == `SMCP_XIP_CLEAR)
                            xip_r <= 1'b0;
                    end
                end
            end
            if (read_next)
            begin
                // fetch ahead so the byte is ready at the next falling edge
                o_rd_req <= 1'b1;
                o_rd_addr <= rd_base;
                addr_r <= rd_base + 1'b1;
            end
        end
    end
    // output byte selection
    reg [7:0] tx_next;
    always @*
    begin
        tx_next = 8'h00;
        if (sleep_r)
            tx_next = 8'h00;
        else if (cmd_r == `SMCP_CMD_STATUS_READ)
            tx_next = status_now;
        else if (cmd_r == `SMCP_CMD_TAMPER && idx_r <= `SMCP_ID_BYTES)
            tx_next = i_tamper_flag ? `SMCP_TAMPER_BAD :
                      `SMCP_TAMPER_OK;
        else if (cmd_r == `SMCP_CMD_IDENTIFY && idx_r <= `SMCP_ID_BYTES)
        begin
            case (idx_r)
                3'h1: tx_next = DEVICE_ID[31:24];
                3'h2: tx_next = DEVICE_ID[23:16];
                3'h3: tx_next = DEVICE_ID[15:8];
                default: tx_next = DEVICE_ID[7:0];
            endcase
        end
        else if (is_read && idx_r >= data_idx)
            tx_next = rd_byte_r;
    end
    wire tx_active = ~sleep_r & ((cmd_r == `SMCP_CMD_STATUS_READ) |
        (cmd_r == `SMCP_CMD_TAMPER) | (cmd_r == `SMCP_CMD_IDENTIFY) |
        (is_read & (idx_r >= data_idx)));

    always @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            tx_r <= 8'h00;
            rd_byte_r <= 8'h00;
            o_so <= 1'b0;
            o_so_oe <= 1'b0;
        end
        else
        begin
            if (i_rd_valid)
                rd_byte_r <= i_rd_data;
            if (cs_n_s)
                o_so_oe <= 1'b0;
            else if (sck_fall && idx_r != 3'h0)
            begin
                if (bit_cnt_r == 3'h0)
                begin
                    o_so <= tx_next[7];
                    tx_r <= {tx_next[6:0], 1'b0};
                    o_so_oe <= tx_active;
                end
                else
                begin
                    o_so <= tx_r[7];
                    tx_r <= {tx_r[6:0], 1'b0};
                end
            end
        end
    end
    // two-entry write buffer between the serial side and the array
    reg v0_nxt, v1_nxt;
    reg [24:0] d0_nxt, d1_nxt;
    always @*
    begin
        o_wr_valid = v0_r;
        o_wr_addr = d0_r[24:8];
        o_wr_data = d0_r[7:0];
        v0_nxt = v0_r;
        v1_nxt = v1_r;
        d0_nxt = d0_r;
        d1_nxt = d1_r;
        if (v0_r && i_wr_ready)
        begin
            v0_nxt = v1_r;
            d0_nxt = d1_r;
            v1_nxt = 1'b0;
        end
        if (push)
        begin
            if (!v0_nxt)
            begin
                v0_nxt = 1'b1;
                d0_nxt = {addr_r, rx_byte};
            end
            else
            begin
                v1_nxt = 1'b1;
                d1_nxt = {addr_r, rx_byte};
            end
        end
    end
    always @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            v0_r <= 1'b0;
            v1_r <= 1'b0;
            d0_r <= 25'h0000000;
            d1_r <= 25'h0000000;
            o_wr_buf_ready <= 1'b1;
            o_status <= `SMCP_SR_RESET;
            o_hw_protect <= 1'b0;
            o_sleep <= 1'b0;
            o_xip <= 1'b0;
        end
        else
        begin
            v0_r <= v0_nxt;
            v1_r <= v1_nxt;
            d0_r <= d0_nxt;
            d1_r <= d1_nxt;
            o_wr_buf_ready <= ~v1_nxt;
            o_status <= status_now;
            o_hw_protect <= hw_prot;
            o_sleep <= sleep_r;
            o_xip <= xip_r;
        end
    end
endmodule

// File: core/smcp_map.vh
// constants for the serial memory command front end
`ifndef SMCP_MAP_VH
`define SMCP_MAP_VH
`define SMCP_CMD_STATUS_READ 8'h05
`define SMCP_CMD_LATCH_SET 8'h06
`define SMCP_CMD_LATCH_CLEAR 8'h04
`define SMCP_CMD_STATUS_WRITE 8'h01
`define SMCP_CMD_READ 8'h03
`define SMCP_CMD_FAST_READ 8'h0B
`define SMCP_CMD_WRITE 8'h02
`define SMCP_CMD_SLEEP 8'hB9
`define SMCP_CMD_WAKE 8'hAB
`define SMCP_CMD_TAMPER 8'h17
`define SMCP_CMD_IDENTIFY 8'h4B
`define SMCP_XIP_SET 8'hEF
`define SMCP_XIP_CLEAR 8'hFF
`define SMCP_SR_LOCK 7
`define SMCP_SR_QUAD 6
`define SMCP_SR_RSV2 5
`define SMCP_SR_RSV1 4
`define SMCP_SR_BP_HI 3
`define SMCP_SR_BP_LO 2
`define SMCP_SR_WEL 1
`define SMCP_SR_RSV0 0
`define SMCP_SR_RESET 8'h00
`define SMCP_ADDR_W 17
`define SMCP_ID_BYTES 3'h4
`define SMCP_TAMPER_BAD 8'hFF
`define SMCP_TAMPER_OK 8'h00
`define SMCP_IDX_ADDR_END 3'h3
`define SMCP_IDX_MODE 3'h4
`define SMCP_IDX_MAX 3'h7
`endif

// File: verif/smcp_host_model.sv
// host serial controller model: select, clock and data out
`timescale 1ns/1ps
module smcp_host_model (
    input wire i_clk_sys,
    input wire i_so,
    output logic o_sck,
    output logic o_cs_n,
    output logic o_si
);
    logic idle_r;
    initial
    begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
        idle_r = 1'b0;
    end
    task automatic gap(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask
    // clock idle level is set before select falls
    task automatic begin_frame(input logic m3);
        o_sck = m3;
        idle_r = m3;
        gap(4);
        o_cs_n = 1'b0;
        gap(4);
    endtask
    // msb first; data moves with clock low, so taken before the rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            o_sck = 1'b0;
            o_si = tx[i];
            gap(4);
            rx[i] = i_so;
            o_sck = 1'b1;
            gap(4);
        end
    endtask
    // only whole bytes are sent; released data line flips
    task automatic end_frame();
        o_sck = idle_r;
        gap(4);
        o_cs_n = 1'b1;
        o_si = ~o_si;
        gap(6);
    endtask
endmodule

// File: verif/smcp_spi_front_checker.sv
// concurrent checks on the serial front end ports
`timescale 1ns/1ps
module smcp_spi_front_checker (
    input wire i_clk_sys,
    input wire i_rst,
    input wire i_sck,
    input wire i_cs_n,
    input wire i_wr_ready,
    input wire o_so_oe,
    input wire [7:0] o_status,
    input wire o_hw_protect,
    input wire o_sleep,
    input wire o_mode3,
    input wire o_wr_valid,
    input wire [16:0] o_wr_addr,
    input wire [7:0] o_wr_data,
    input wire o_rd_req
);
    wire [1:0] bp = o_status[3:2];
    wire blk = bp == 2'b11 || (bp == 2'b10 && o_wr_addr[16]) ||
        (bp == 2'b01 && o_wr_addr[16:15] == 2'b11);
    default clocking @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);
    rd_pulse_a: assert property (o_rd_req |=> !o_rd_req)
        else $error("read request longer than one cycle");
    quad_zero_a: assert property (o_status[6] == 1'b0)
        else $error("quad mode flag set");
    oe_release_a: assert property (i_cs_n [*6] |-> !o_so_oe)
        else $error("output still driven after select high");
    wr_hold_a: assert property (o_wr_valid && !i_wr_ready |=>
        o_wr_valid && $stable(o_wr_addr) && $stable(o_wr_data))
        else $error("write head changed while stalled");
    wr_prot_a: assert property ($rose(o_wr_valid) |->
        o_status[1] && !blk)
        else $error("write passed to protected place");
    mode_pick_a: assert property ($fell(i_cs_n) |->
        ##6 o_mode3 == $past(i_sck, 6))
        else $error("clock mode not taken at select fall");
    sleep_quiet_a: assert property (o_sleep |-> !o_so_oe && !o_rd_req)
        else $error("activity while asleep");
    hw_freeze_a: assert property (o_hw_protect && $past(o_hw_protect)
        |-> $stable(o_status[7:2]))
        else $error("protect bits moved under hardware protection");
endmodule
bind smcp_spi_front smcp_spi_front_checker u_chk (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_sck(i_sck),
    .i_cs_n(i_cs_n),
    .i_wr_ready(i_wr_ready),
    .o_so_oe(o_so_oe),
    .o_status(o_status),
    .o_hw_protect(o_hw_protect),
    .o_sleep(o_sleep),
    .o_mode3(o_mode3),
    .o_wr_valid(o_wr_valid),
    .o_wr_addr(o_wr_addr),
    .o_wr_data(o_wr_data),
    .o_rd_req(o_rd_req)
);

// File: verif/smcp_spi_front_bench.sv
// self-checking bench for the serial command front end
`timescale 1ns/1ps
module smcp_spi_front_bench;
    localparam logic [31:0] BENCH_ID = 32'h13572468; // arbitrary value
    // row: mode3, wp_n, byte count(2), command, argument, expected status
    localparam logic [27:0] ROWS [7] = '{28'h5060002, 28'hD040000,
        28'h6010C00, 28'hD060002, 28'h601FFBF, 28'hA0180BF, 28'h6010002};
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic i_wp_n = 1'b1;
    logic i_tamper_flag = 1'b0;
    logic i_wr_ready = 1'b0;
    logic i_rd_valid = 1'b0;
    logic [7:0] i_rd_data = 8'h00;
    wire i_sck, i_cs_n, i_si, o_so, o_so_oe, o_hw_protect, o_sleep;
    wire o_xip, o_mode3, o_wr_valid, o_wr_buf_ready, o_rd_req;
    wire [7:0] o_status, o_wr_data;
    wire [16:0] o_wr_addr, o_rd_addr;
    // an undriven output line reads inverted, so a missing enable shows up
    wire so_line = o_so_oe ? o_so : ~o_so;
    logic [63:0] rxw;
    logic [24:0] wq [$];
    int fail_count = 0;
    int compares = 0;
    always #50 i_clk_sys = ~i_clk_sys;
    smcp_host_model u_host (
        .i_clk_sys(i_clk_sys),
        .i_so(so_line),
        .o_sck(i_sck),
        .o_cs_n(i_cs_n),
        .o_si(i_si)
    );
    smcp_spi_front #(.DEVICE_ID(BENCH_ID)) u_dut (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_sck(i_sck),
        .i_cs_n(i_cs_n),
        .i_si(i_si),
        .i_wp_n(i_wp_n),
        .i_tamper_flag(i_tamper_flag),
        .i_wr_ready(i_wr_ready),
        .i_rd_valid(i_rd_valid),
        .i_rd_data(i_rd_data),
        .o_so(o_so),
        .o_so_oe(o_so_oe),
        .o_status(o_status),
        .o_hw_protect(o_hw_protect),
        .o_sleep(o_sleep),
        .o_xip(o_xip),
        .o_mode3(o_mode3),
        .o_wr_valid(o_wr_valid),
        .o_wr_addr(o_wr_addr),
        .o_wr_data(o_wr_data),
        .o_wr_buf_ready(o_wr_buf_ready),
        .o_rd_req(o_rd_req),
        .o_rd_addr(o_rd_addr)
    );
    // array side answers one cycle after each request
    always @(negedge i_clk_sys)
    begin
        i_rd_valid <= o_rd_req;
        i_rd_data <= o_rd_addr[7:0] ^ 8'h5A;
    end
    always @(posedge i_clk_sys)
        if (o_wr_valid && i_wr_ready)
            wq.push_back({o_wr_addr, o_wr_data});
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic run(input logic m3, input int n, input logic [63:0] tx);
        logic [7:0] rx;
        u_host.begin_frame(m3);
        for (int k = 0; k < n; k++)
        begin
            u_host.xfer(tx[63-8*k -: 8], rx);
            rxw = {rxw[55:0], rx};
        end
        u_host.end_frame();
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(negedge i_clk_sys);
        i_rst = 1'b0;
        repeat (4) @(negedge i_clk_sys);
        chk("status", 8'h00, o_status);
        chk("buf ready", 1'b1, o_wr_buf_ready);
        chk("xip", 1'b0, o_xip);
        foreach (ROWS[r])
        begin
            i_wp_n = ROWS[r][26];
            run(ROWS[r][27], ROWS[r][25:24], {ROWS[r][23:8], 48'h0});
            run(~ROWS[r][27], 2, {8'h05, 56'h0});
            chk("row", ROWS[r][7:0], rxw[7:0]);
            chk("hw", ROWS[r][7] & ~ROWS[r][26], o_hw_protect);
        end
        // upper quarter locked, write wraps, sink stalls until full
        run(0, 2, {8'h01, 8'h04, 48'h0});
        run(1, 8, {8'h02, 24'h01FFFF, 32'hA1A2A3A4});
        chk("buf full", 1'b0, o_wr_buf_ready);
        i_wr_ready = 1'b1;
        for (int t = 0; t < 40 && wq.size() < 2; t++)
            @(negedge i_clk_sys);
        if (wq.size() < 2)
        begin
            fail_count++;
            report_and_stop();
        end
        repeat (4) @(negedge i_clk_sys);
        chk("pushes", 2, wq.size());
        chk("push 0", {17'h00000, 8'hA2}, wq[0]);
        chk("push 1", {17'h00001, 8'hA3}, wq[1]);
        chk("buf free", 1'b1, o_wr_buf_ready);
        run(0, 6, {8'h03, 24'h000010, 32'h0});
        chk("read", 16'h4A4B, rxw[15:0]);
        i_tamper_flag = 1'b1;
        run(1, 5, {8'h17, 56'h0});
        chk("tamper", 32'hFFFFFFFF, rxw[31:0]);
        run(0, 5, {8'h4B, 56'h0});
        chk("id", BENCH_ID, rxw[31:0]);
        run(1, 6, {8'h0B, 24'h000020, 8'hEF, 24'h0});
        chk("xip on", 1'b1, o_xip);
        chk("fast", 8'h7A, rxw[7:0]);
        run(0, 5, {24'h000021, 8'hFF, 32'h0});
        chk("xip off", 1'b0, o_xip);
        chk("xip read", 8'h7B, rxw[7:0]);
        run(0, 1, {8'hB9, 56'h0});
        chk("sleep", 1'b1, o_sleep);
        run(0, 1, {8'h04, 56'h0});
        run(0, 1, {8'hAB, 56'h0});
        chk("awake", 1'b0, o_sleep);
        run(0, 2, {8'h05, 56'h0});
        chk("latch kept", 8'h06, rxw[7:0]);
        // mid-run reset: status clears and the link works again
        i_rst = 1'b1;
        repeat (2) @(negedge i_clk_sys);
        i_rst = 1'b0;
        repeat (4) @(negedge i_clk_sys);
        chk("reset status", 8'h00, o_status);
        run(1, 2, {8'h05, 56'h0});
        chk("reset read", 8'h00, rxw[7:0]);
        report_and_stop();
    end
endmodule
